// ===== adc_ctrl_top.sv
// adc_ctrl_top.sv: converter control, apb registers and interrupt
// assumes an external converter core that pulses conv_done with data
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module adc_ctrl_top
  import adc_pkg::*;
(
  // clock, reset, enable
  input logic pclk,
  input logic presetn,
  input logic ce,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core
  output logic conv_enable,
  output logic conv_start,
  output logic [CHAN_W-1:0] conv_channel,
  input logic conv_done,
  input logic [RESULT_W-1:0] conv_data,
  // pin configuration
  input logic reduced_pins,
  output logic [PIN_CNT-1:0] pin_analog,
  output logic vref_pos_ext,
  output logic vref_neg_ext,
  // interrupt
  output logic irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] config_ff;
  logic [7:0] nxt_config;
  logic enable_ff;
  logic nxt_enable;
  logic [CHAN_W-1:0] chan_ff;
  logic [CHAN_W-1:0] nxt_chan;
  logic go_ff;
  logic nxt_go;
  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic conv_start_ff;
  logic [INT_W-1:0] status_ff;
  logic [INT_W-1:0] nxt_status;
  logic [INT_W-1:0] mask_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [PIN_CNT-1:0] pin_analog_ff;
  logic vref_pos_ff;
  logic vref_neg_ff;
  logic [7:0] res_high;
  logic [7:0] res_low;

  // ****************************************
  // configuration decoder and result pair
  // ****************************************
  cfg_if cfg ();

  assign cfg.code = config_ff[CFG_CODE_LSB +: CFG_CODE_W];
  assign cfg.reduced = reduced_pins;

  port_config_decoder u_dec
  (
    .cfg (cfg.dec)
  );

  wire done_ev;

  result_formatter u_fmt
  (
    .pclk (pclk),
    .presetn (presetn),
    .ce (ce),
    .load (done_ev),
    .justify (config_ff[CFG_JUSTIFY_BIT]),
    .raw (conv_data),
    .res_high_ff (res_high),
    .res_low_ff (res_low)
  );

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_en = access & pwrite & ce;
  wire sel_config = paddr == reg_addr(IDX_CONFIG);
  wire sel_control = paddr == reg_addr(IDX_CONTROL);
  wire sel_res_high = paddr == reg_addr(IDX_RES_HIGH);
  wire sel_res_low = paddr == reg_addr(IDX_RES_LOW);
  wire sel_status = paddr == reg_addr(IDX_INT_STATUS);
  wire sel_mask = paddr == reg_addr(IDX_INT_MASK);
  wire sel_port = paddr == reg_addr(IDX_PORT_STATE);
  wire mapped = sel_config | sel_control | sel_res_high | sel_res_low |
                sel_status | sel_mask | sel_port;

  // zero wait states, freeze while clock enable is low
  assign pready = ce;
  assign pslverr = access & ce & ~mapped;

  wire wr_config = wr_en & sel_config;
  wire wr_control = wr_en & sel_control;
  wire wr_status = wr_en & sel_status;
  wire wr_mask = wr_en & sel_mask;

  // ****************************************
  // configuration register
  // ****************************************
  // bits six to four unstored
  assign nxt_config = {pwdata[CFG_JUSTIFY_BIT], 3'b000,
                       pwdata[CFG_CODE_LSB +: CFG_CODE_W]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_ff <= CONFIG_RST;
    else if (wr_config)
      config_ff <= nxt_config;
  end

  // ****************************************
  // control register and start checks
  // ****************************************
  wire idle = state_ff == CONV_IDLE;
  wire busy = state_ff == CONV_BUSY;
  wire wr_enable = pwdata[CTRL_ENABLE_BIT];
  wire [CHAN_W-1:0] wr_chan = pwdata[CTRL_CHAN_LSB +: CHAN_W];
  wire go_wr = wr_control & pwdata[CTRL_GO_BIT];
  wire chan_ok = cfg.analog[wr_chan];
  wire start_ok = go_wr & idle & wr_enable & chan_ok;
  wire start_bad = go_wr & idle & ~(wr_enable & chan_ok);
  wire abort = busy & wr_control & ~wr_enable;

  assign done_ev = ce & busy & conv_done;

  // channel follows writes only while idle, enable follows them while idle and clears while busy
  assign nxt_enable = wr_control && (idle || !wr_enable) ? wr_enable
                                                         : enable_ff;
  assign nxt_chan = wr_control && idle ? wr_chan : chan_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_ff <= 1'b0;
      chan_ff <= 3'h0;
    end
    else if (ce)
    begin
      enable_ff <= nxt_enable;
      chan_ff <= nxt_chan;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_go = go_ff;
    case (state_ff)
      CONV_IDLE:
      begin
        if (start_ok)
        begin
          nxt_state = CONV_BUSY;
          nxt_go = 1'b1;
        end
      end
      CONV_BUSY:
      begin
        if (conv_done || abort)
        begin
          nxt_state = CONV_IDLE;
          nxt_go = 1'b0;
        end
      end
      default:
      begin
        nxt_state = CONV_IDLE;
        nxt_go = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= CONV_IDLE;
      go_ff <= 1'b0;
      conv_start_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      go_ff <= nxt_go;
      conv_start_ff <= start_ok;
    end
  end

  assign conv_start = conv_start_ff;
  assign conv_enable = enable_ff;
  assign conv_channel = chan_ff;

  // ****************************************
  // interrupt status and mask
  // ****************************************
  wire [INT_W-1:0] int_set = {start_bad, done_ev};
  wire [INT_W-1:0] int_clr = wr_status ? pwdata[INT_W-1:0] : 2'h0;

  assign nxt_status = (status_ff & ~int_clr) | int_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_ff <= 2'h0;
    else if (ce)
      status_ff <= nxt_status;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_ff <= MASK_RST;
    else if (wr_mask)
      mask_ff <= pwdata[INT_W-1:0];
  end

  assign irq = |(status_ff & mask_ff);

  // ****************************************
  // pin configuration outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_analog_ff <= 8'hFF;
      vref_pos_ff <= 1'b0;
      vref_neg_ff <= 1'b0;
    end
    else if (ce)
    begin
      pin_analog_ff <= cfg.analog;
      vref_pos_ff <= cfg.vref_pos;
      vref_neg_ff <= cfg.vref_neg;
    end
  end

  assign pin_analog = pin_analog_ff;
  assign vref_pos_ext = vref_pos_ff;
  assign vref_neg_ext = vref_neg_ff;

  // ****************************************
  // read data
  // ****************************************
  wire [DATA_W-1:0] rd_config = {24'h0000_00, config_ff};
  wire [DATA_W-1:0] rd_control = {26'h000_0000, chan_ff, go_ff, 1'b0,
                                  enable_ff};
  wire [DATA_W-1:0] rd_high = {24'h0000_00, res_high};
  wire [DATA_W-1:0] rd_low = {24'h0000_00, res_low};
  wire [DATA_W-1:0] rd_status = {30'h0000_0000, status_ff};
  wire [DATA_W-1:0] rd_mask = {30'h0000_0000, mask_ff};
  wire [DATA_W-1:0] rd_port = {17'h0_0000, cfg.reduced, cfg.nchan,
                               vref_pos_ff, vref_neg_ff, pin_analog_ff};
  wire [DATA_W-1:0] rd_mux = ({DATA_W{sel_config}} & rd_config) |
                             ({DATA_W{sel_control}} & rd_control) |
                             ({DATA_W{sel_res_high}} & rd_high) |
                             ({DATA_W{sel_res_low}} & rd_low) |
                             ({DATA_W{sel_status}} & rd_status) |
                             ({DATA_W{sel_mask}} & rd_mask) |
                             ({DATA_W{sel_port}} & rd_port);

  // captured in setup, held through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (ce && setup)
      prdata_ff <= rd_mux;
  end

  assign prdata = prdata_ff;

endmodule // adc_ctrl_top

// ===== adc_pkg.sv
// adc_pkg.sv: constants, register map and types of the converter control
// assumes apb with 32-bit data and word-aligned register slots
package adc_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ****************************************
  // register indices, byte address is four times
  // ****************************************
  localparam logic [7:0] IDX_CONFIG = 8'h9F;
  localparam logic [7:0] IDX_CONTROL = 8'h1F;
  localparam logic [7:0] IDX_RES_HIGH = 8'h1E;
  localparam logic [7:0] IDX_RES_LOW = 8'h9E;
  localparam logic [7:0] IDX_INT_STATUS = 8'hA0;
  localparam logic [7:0] IDX_INT_MASK = 8'hA1;
  localparam logic [7:0] IDX_PORT_STATE = 8'hA2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CFG_JUSTIFY_BIT = 7;
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_CODE_W = 4;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_CHAN_LSB = 3;
  localparam int CHAN_W = 3;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_REFUSED_BIT = 1;
  localparam int INT_W = 2;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int RESULT_W = 10;
  localparam int PIN_CNT = 8;
  localparam int JUSTIFY_PAD = 6;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [7:0] REDUCED_KEEP = 8'h1F;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0]
  {
    CONV_IDLE = 2'b00,
    CONV_BUSY = 2'b01
  } conv_state_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

endpackage

// ===== cfg_if.sv
// cfg_if.sv: port configuration code and its decoded pin map
// assumes one producer of the code and one decoder
`timescale 1ns/1ps
interface cfg_if;
  logic [3:0] code;
  logic reduced;
  logic [7:0] analog;
  logic vref_pos;
  logic vref_neg;
  logic [3:0] nchan;

  modport ctl (output code, output reduced, input analog, input vref_pos,
               input vref_neg, input nchan);
  modport dec (input code, input reduced, output analog, output vref_pos,
               output vref_neg, output nchan);
endinterface

// ===== port_config_decoder.sv
// port_config_decoder.sv: pin map, references and channel count
// assumes code and reduced flag are steady from flip-flops or straps
`timescale 1ns/1ps
module port_config_decoder
  import adc_pkg::*;
(
  // configuration link
  cfg_if.dec cfg
);

  // ****************************************
  // code table: {vref+ ext, vref- ext, analog map}
  // ****************************************
  function automatic logic [9:0] decode(input logic [3:0] c);
    case (c)
      4'h0: decode = {2'b00, 8'hFF};
      4'h1: decode = {2'b10, 8'hF7};
      4'h2: decode = {2'b00, 8'h1F};
      4'h3: decode = {2'b10, 8'h17};
      4'h4: decode = {2'b00, 8'h0B};
      4'h5: decode = {2'b10, 8'h03};
      4'h6: decode = {2'b00, 8'h00};
      4'h7: decode = {2'b00, 8'h00};
      4'h8: decode = {2'b11, 8'hF3};
      4'h9: decode = {2'b00, 8'h3F};
      4'hA: decode = {2'b10, 8'h37};
      4'hB: decode = {2'b11, 8'h33};
      4'hC: decode = {2'b11, 8'h13};
      4'hD: decode = {2'b11, 8'h03};
      4'hE: decode = {2'b00, 8'h01};
      default: decode = {2'b11, 8'h01};
    endcase
  endfunction

  logic [9:0] row;
  logic [7:0] keep;
  logic [3:0] cnt [PIN_CNT:0];

  assign row = decode(cfg.code);
  assign keep = cfg.reduced ? REDUCED_KEEP : 8'hFF;
  assign cfg.analog = row[7:0] & keep;
  assign cfg.vref_pos = row[9];
  assign cfg.vref_neg = row[8];

  assign cnt[0] = 4'h0;
  genvar i;
  generate
    for (i = 0; i < PIN_CNT; i++)
    begin : g_cnt
      assign cnt[i+1] = cnt[i] + {3'b000, cfg.analog[i]};
    end
  endgenerate
  assign cfg.nchan = cnt[PIN_CNT];

endmodule // port_config_decoder

// ===== result_formatter.sv
// result_formatter.sv: justified result byte pair
// assumes load is a one-cycle pulse with raw valid
`timescale 1ns/1ps
module result_formatter
  import adc_pkg::*;
(
  // clock and reset
  input logic pclk,
  input logic presetn,
  input logic ce,
  // result in
  input logic load,
  input logic justify,
  input logic [RESULT_W-1:0] raw,
  // byte pair out
  output logic [7:0] res_high_ff,
  output logic [7:0] res_low_ff
);

  logic [7:0] nxt_high;
  logic [7:0] nxt_low;

  assign nxt_high = justify ? {{JUSTIFY_PAD{1'b0}}, raw[9:8]} : raw[9:2];
  assign nxt_low = justify ? raw[7:0] : {raw[1:0], {JUSTIFY_PAD{1'b0}}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res_high_ff <= 8'h00;
      res_low_ff <= 8'h00;
    end
    else if (ce && load)
    begin
      res_high_ff <= nxt_high;
      res_low_ff <= nxt_low;
    end
  end

endmodule // result_formatter

// ===== adc_ctrl_props.sv
// adc_ctrl_props.sv: port assertions of the converter control
// assumes a bind onto adc_ctrl_top, one clock domain
`timescale 1ns/1ps
module adc_ctrl_props
  import adc_pkg::*;
(
  // clock and reset
  input logic pclk,
  input logic presetn,
  input logic ce,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [DATA_W-1:0] pwdata,
  // converter, pins, interrupt
  input logic conv_start,
  input logic conv_done,
  input logic reduced_pins,
  input logic [PIN_CNT-1:0] pin_analog,
  input logic vref_pos_ext,
  input logic vref_neg_ext,
  input logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************
  // write decode
  // ****************************************
  wire wr = psel && penable && pwrite && ce;
  wire wr_cfg = wr && paddr == {2'b00, IDX_CONFIG, 2'b00};
  wire ctl_hit = paddr == {2'b00, IDX_CONTROL, 2'b00};
  wire wr_go = wr && ctl_hit && pwdata[CTRL_GO_BIT];
  // ****************************************
  // properties
  // ****************************************
  property p_reset_map;
    $rose(presetn) |-> pin_analog == 8'hFF && !vref_pos_ext && !vref_neg_ext;
  endproperty
  a_reset_map: assert property (p_reset_map)
    else $error("pin map wrong after reset");
  property p_all_analog;
    wr_cfg && pwdata[3:0] == 4'h0 && !reduced_pins |-> ##2 pin_analog == 8'hFF;
  endproperty
  a_all_analog: assert property (p_all_analog)
    else $error("code zero not all analog");
  property p_all_digital;
    wr_cfg && pwdata[3:1] == 3'h3 |-> ##2 pin_analog == 8'h00;
  endproperty
  a_all_digital: assert property (p_all_digital)
    else $error("code six or seven not all digital");
  property p_vref_both;
    wr_cfg && pwdata[3:0] == 4'h8 |-> ##2 vref_pos_ext && vref_neg_ext;
  endproperty
  a_vref_both: assert property (p_vref_both)
    else $error("code eight not using both pin references");
  property p_vref_none;
    wr_cfg && pwdata[3:0] == 4'h0 |-> ##2 !vref_pos_ext && !vref_neg_ext;
  endproperty
  a_vref_none: assert property (p_vref_none)
    else $error("code zero not using supply references");
  property p_reduced;
    reduced_pins && $past(reduced_pins) && $past(presetn)
      |-> (pin_analog & ~REDUCED_KEEP) == 8'h00;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("absent channel marked analog");
  property p_start_cause;
    conv_start |-> $past(wr_go);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start without go write");
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start longer than one cycle");
  property p_irq_rise;
    $rose(irq) |-> $past(conv_done) || $past(wr) || $past(conv_done, 2)
      || $past(wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without cause");
endmodule // adc_ctrl_props

bind adc_ctrl_top adc_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .conv_start(conv_start), .conv_done(conv_done),
  .reduced_pins(reduced_pins), .pin_analog(pin_analog),
  .vref_pos_ext(vref_pos_ext), .vref_neg_ext(vref_neg_ext), .irq(irq)
);

// ===== tb_adc_port_config_and_result.sv
// tb_adc_port_config_and_result.sv: self-checking bench of adc_ctrl_top
// assumes zero-wait apb slave and a converter core driven by the bench
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb_adc_port_config_and_result
  import adc_pkg::*;
;
  logic pclk, presetn, ce, psel, penable, pwrite, err;
  logic conv_done, reduced_pins, pready, pslverr, conv_enable, conv_start;
  logic vref_pos_ext, vref_neg_ext, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [CHAN_W-1:0] conv_channel;
  logic [RESULT_W-1:0] conv_data;
  logic [PIN_CNT-1:0] pin_analog;
  int n_mismatch, n_tests;
  logic [7:0] amap [16] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03,
    8'h00, 8'h00, 8'hF3, 8'h3F, 8'h37, 8'h33, 8'h13, 8'h03, 8'h01, 8'h01};
  logic [3:0] cnt [16] = '{4'h8, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h0, 4'h0,
    4'h6, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h1};
  localparam logic [15:0] VP = 16'hBD2A;
  localparam logic [15:0] VN = 16'hB900;
  localparam logic [11:0] A_CFG = {2'b00, IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_HI = {2'b00, IDX_RES_HIGH, 2'b00};
  localparam logic [11:0] A_LO = {2'b00, IDX_RES_LOW, 2'b00};
  localparam logic [11:0] A_STS = {2'b00, IDX_INT_STATUS, 2'b00};
  localparam logic [11:0] A_MSK = {2'b00, IDX_INT_MASK, 2'b00};
  localparam logic [11:0] A_PST = {2'b00, IDX_PORT_STATE, 2'b00};

  adc_ctrl_top DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_enable(conv_enable), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_data(conv_data), .reduced_pins(reduced_pins),
    .pin_analog(pin_analog), .vref_pos_ext(vref_pos_ext),
    .vref_neg_ext(vref_neg_ext), .irq(irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ****************************************
  // bus and converter tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic conv(input logic j, input logic [9:0] d, input logic m);
    logic [7:0] eh, el;
    int k;
    eh = j ? {6'h00, d[9:8]} : d[9:2];
    el = j ? d[7:0] : {d[1:0], 6'h00};
    apb(1'b1, A_MSK, {31'h0000_0000, m});
    apb(1'b1, A_CFG, {24'h00_0000, j, 7'h00});
    repeat (4) @(posedge pclk);
    apb(1'b1, A_CTL, 32'h0000_000D);
    for (k = 0; k < 20 && conv_start !== 1'b1; k++) @(negedge pclk);
    `CHK("start", conv_start, 1'b1)
    `CHK("channel", conv_channel, 3'h1)
    `CHK("enable", conv_enable, 1'b1)
    apb(1'b0, A_CTL, 32'h0000_0000);
    `CHK("go busy", rd[CTRL_GO_BIT], 1'b1)
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge pclk);
    conv_done <= 1'b0;
    conv_data <= ~d;
    apb(1'b0, A_HI, 32'h0000_0000);
    `CHK("res high", rd, {24'h00_0000, eh})
    apb(1'b0, A_LO, 32'h0000_0000);
    `CHK("res low", rd, {24'h00_0000, el})
    apb(1'b0, A_CTL, 32'h0000_0000);
    `CHK("go done", rd[CTRL_GO_BIT], 1'b0)
    apb(1'b0, A_STS, 32'h0000_0000);
    `CHK("status", rd, 32'h0000_0001)
    `CHK("irq masked", irq, m)
    apb(1'b1, A_MSK, 32'h0000_0001);
    @(negedge pclk);
    `CHK("irq set", irq, 1'b1)
    apb(1'b1, A_STS, 32'h0000_0001);
    @(negedge pclk);
    `CHK("irq clear", irq, 1'b0)
    apb(1'b0, A_STS, 32'h0000_0000);
    `CHK("status clear", rd, 32'h0000_0000)
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    conv_done = 1'b0;
    conv_data = 10'h000;
    reduced_pins = 1'b0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CFG, 32'h0000_0000);
    `CHK("cfg reset", rd, 32'h0000_0000)
    apb(1'b0, A_PST, 32'h0000_0000);
    `CHK("map reset", rd, 32'h0000_20FF)
    `CHK("pins reset", pin_analog, 8'hFF)
    $display("test reset done");
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, A_CFG, {24'h00_0000, 4'hF, c[3:0]});
      apb(1'b0, A_CFG, 32'h0000_0000);
      `CHK("cfg read", rd, {24'h00_0000, 4'h8, c[3:0]})
      apb(1'b0, A_PST, 32'h0000_0000);
      `CHK("refs", rd, {18'h0_0000, cnt[c], VP[c], VN[c], amap[c]})
      `CHK("pins", pin_analog, amap[c])
      `CHK("vref pos", vref_pos_ext, VP[c])
      `CHK("vref neg", vref_neg_ext, VN[c])
    end
    $display("test decode done");
    reduced_pins <= 1'b1;
    apb(1'b1, A_CFG, 32'h0000_0000);
    apb(1'b0, A_PST, 32'h0000_0000);
    `CHK("reduced flag", rd[14], 1'b1)
    `CHK("reduced pins", pin_analog, 8'h1F)
    reduced_pins <= 1'b0;
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK("unmapped err", err, 1'b1)
    `CHK("unmapped data", rd, 32'h0000_0000)
    $display("test reduced done");
    conv(1'b0, 10'h2B5, 1'b1);
    conv(1'b1, 10'h16A, 1'b0);
    apb(1'b1, A_CFG, 32'h0000_0006);
    apb(1'b1, A_CTL, 32'h0000_000D);
    apb(1'b0, A_CTL, 32'h0000_0000);
    `CHK("refused go", rd[CTRL_GO_BIT], 1'b0)
    apb(1'b0, A_STS, 32'h0000_0000);
    `CHK("refused flag", rd, 32'h0000_0002)
    $display("test convert done");
    stop_test();
  end
endmodule // tb_adc_port_config_and_result
